// *** inc/tbcd_pkg.sv ***
// constants and types shared by the type b card command decoder
package tbcd_pkg;
  localparam logic [7:0] CMD_REQ = 8'h05;
  localparam logic [7:0] CMD_ATTR = 8'h1d;
  localparam logic [7:0] CMD_HLT = 8'h50;
  localparam logic [7:0] INS_SEL = 8'ha4;
  localparam logic [7:0] INS_VER = 8'h20;
  localparam logic [7:0] INS_RD = 8'hb0;
  localparam logic [7:0] INS_WR = 8'hd6;
  localparam logic [7:0] AFI_ANY = 8'h00;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam int PAR_WAKE_BIT = 3;
  localparam logic [1:0] PCB_IBLK = 2'b00;
  localparam logic [7:0] SPD_LOW = 8'h80;
  localparam logic [7:0] SPD_ALL = 8'hb3;
  localparam logic [7:0] PROTO2_VAL = 8'h81;
  localparam int LEN_W = 9;
  localparam logic [8:0] MAX_FRAME = 9'h100;
  localparam logic [8:0] LEN_SAT = 9'h101;
  localparam logic [8:0] LEN_ZERO = 9'h000;
  localparam logic [8:0] LEN_ONE = 9'h001;
  localparam logic [8:0] LEN_TWO = 9'h002;
  typedef enum logic [1:0] {
    TBCD_IDLE,
    TBCD_READY,
    TBCD_ACTIVE,
    TBCD_HALT
  } tbcd_state_t;
endpackage

// *** logic/tbcd_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
module tbcd_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);
  logic meta_q;
  logic meta_d;
  logic q_d;

  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule

// *** logic/tbcd_decoder.sv ***
// type b card command decoder: frame capture on link clock, decode on core
// Summary of operation
// - family value 0x00 in a request gets an answer unless the card is active, or halted without wake-up.
// - upper-nibble-only family value must match stored upper nibble.
// - lower-nibble-only family value must match stored lower nibble.
// - any other family value must match the stored byte exactly.
// - command byte 0x05 is the request or wake-up identification command.
// - command 0x1d exchanges parameters and enables higher-level commands.
// - command 0x50 puts the card into the halted state.
// - instruction 0xa4 is accepted without any internal processing.
// - instruction 0x20 starts a password authentication.
// - instruction 0xb0 reads own memory, or host data in tunnel mode.
// - instruction 0xd6 writes own memory, or the host in tunnel mode.
// - wake-up answered in halt, idle or ready; plain request only in idle or ready.
// - the three top bits of the parameter byte are ignored.
// - slot count taken as one; low three parameter bits ignored.
// - frames longer than 256 data bytes are discarded.
// - speed limit bit forces protocol byte one to 0x80.
// - protocol byte three holds frame waiting integer over zero nibble.
`timescale 1ns/1ps
module tbcd_decoder (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic rx_sof,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_eof,
  input wire logic [7:0] sys_afi,
  input wire logic [3:0] fwi,
  input wire logic radio_speed_limit_bit,
  input wire logic typeb_high_speed_bit,
  input wire logic tunnel_mode,
  output logic rx_drop,
  output logic atqb_send,
  output logic [7:0] atqb_proto1,
  output logic [7:0] atqb_proto2,
  output logic [7:0] atqb_proto3,
  output logic attrib_done,
  output logic halt_done,
  output logic select_done,
  output logic verify_req,
  output logic mem_rd_req,
  output logic host_rd_req,
  output logic mem_wr_req,
  output logic host_wr_req,
  output logic card_active
);
  // ---------------- link domain: frame capture ----------------
  logic [8:0] cnt_q, cnt_d;
  logic over_q, over_d;
  logic [7:0] b0_q, b0_d, b1_q, b1_d, b2_q, b2_d;
  logic [7:0] s0_q, s0_d, s1_q, s1_d, s2_q, s2_d;
  logic req_q, req_d;
  logic drop_d;
  logic ack_l;
  logic busy;

  assign busy = req_q ^ ack_l;
  always_comb begin
    cnt_d = cnt_q;
    over_d = over_q;
    b0_d = b0_q;
    b1_d = b1_q;
    b2_d = b2_q;
    s0_d = s0_q;
    s1_d = s1_q;
    s2_d = s2_q;
    req_d = req_q;
    drop_d = 1'b0;
    if (rx_sof) begin
      cnt_d = tbcd_pkg::LEN_ZERO;
      over_d = 1'b0;
      b0_d = 8'h00;
      b1_d = 8'h00;
      b2_d = 8'h00;
    end else if (rx_valid) begin
      if (cnt_q == tbcd_pkg::LEN_ZERO) b0_d = rx_byte;
      if (cnt_q == tbcd_pkg::LEN_ONE) b1_d = rx_byte;
      if (cnt_q == tbcd_pkg::LEN_TWO) b2_d = rx_byte;
      if (cnt_q != tbcd_pkg::LEN_SAT) cnt_d = cnt_q + 9'h001;
      if (cnt_q >= tbcd_pkg::MAX_FRAME) over_d = 1'b1;
    end else if (rx_eof) begin
      // the snapshot is held until the core returns the ack toggle
      if (over_q || busy || cnt_q == tbcd_pkg::LEN_ZERO) begin
        drop_d = 1'b1;
      end else begin
        s0_d = b0_q;
        s1_d = b1_q;
        s2_d = b2_q;
        req_d = ~req_q;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 9'h000;
      over_q <= 1'b0;
      b0_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      s0_q <= 8'h00;
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      req_q <= 1'b0;
      rx_drop <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      over_q <= over_d;
      b0_q <= b0_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      s0_q <= s0_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
      req_q <= req_d;
      rx_drop <= drop_d;
    end
  end

  property p_len;
    @(posedge link_clk) disable iff (!rst_b)
      rx_eof && !rx_sof && !rx_valid && over_q |=> $stable(req_q);
  endproperty
  a_len: assert property (p_len) else $error("long frame forwarded");

  // ---------------- crossing ----------------
  logic req_c;
  logic seen_q, seen_d;
  logic new_cmd;

  tbcd_sync u_req_sync (
    .clk(core_clk),
    .rst_b(rst_b),
    .d(req_q),
    .q(req_c)
  );
  tbcd_sync u_ack_sync (
    .clk(link_clk),
    .rst_b(rst_b),
    .d(seen_q),
    .q(ack_l)
  );

  assign new_cmd = req_c ^ seen_q;
  assign seen_d = req_c;
  // ---------------- core domain: decode ----------------
  function automatic logic afi_match(input logic [7:0] cmd_afi,
                                     input logic [7:0] own_afi);
    if (cmd_afi == tbcd_pkg::AFI_ANY) afi_match = 1'b1;
    else if (cmd_afi[3:0] == tbcd_pkg::NIB_ZERO)
      afi_match = cmd_afi[7:4] == own_afi[7:4];
    else if (cmd_afi[7:4] == tbcd_pkg::NIB_ZERO)
      afi_match = cmd_afi[3:0] == own_afi[3:0];
    else afi_match = cmd_afi == own_afi;
  endfunction

  tbcd_pkg::tbcd_state_t st_q, st_d;
  logic wake;
  logic atqb_d, attr_d, halt_d, sel_d, ver_d;
  logic mrd_d, hrd_d, mwr_d, hwr_d;
  logic [7:0] p1_d, p3_d;

  // s0..s2 are stable while new_cmd is high: the link holds them until ack
  // only bit 3 is looked at; bits 7-5 and the slot bits 2-0 are ignored
  assign wake = s2_q[tbcd_pkg::PAR_WAKE_BIT];

  always_comb begin
    st_d = st_q;
    atqb_d = 1'b0;
    attr_d = 1'b0;
    halt_d = 1'b0;
    sel_d = 1'b0;
    ver_d = 1'b0;
    mrd_d = 1'b0;
    hrd_d = 1'b0;
    mwr_d = 1'b0;
    hwr_d = 1'b0;
    p1_d = atqb_proto1;
    p3_d = atqb_proto3;
    if (new_cmd) begin
      if (st_q == tbcd_pkg::TBCD_ACTIVE) begin
        if (s0_q[7:6] == tbcd_pkg::PCB_IBLK) begin
          unique case (s2_q)
            tbcd_pkg::INS_SEL: sel_d = 1'b1;
            tbcd_pkg::INS_VER: ver_d = 1'b1;
            tbcd_pkg::INS_RD: begin
              hrd_d = tunnel_mode;
              mrd_d = !tunnel_mode;
            end
            tbcd_pkg::INS_WR: begin
              hwr_d = tunnel_mode;
              mwr_d = !tunnel_mode;
            end
            default: ;
          endcase
        end
      end else begin
        unique case (s0_q)
          tbcd_pkg::CMD_REQ: begin
            // halted cards wake only on the wake-up form
            if ((st_q != tbcd_pkg::TBCD_HALT || wake) &&
                afi_match(s1_q, sys_afi)) begin
              st_d = tbcd_pkg::TBCD_READY;
              atqb_d = 1'b1;
              if (radio_speed_limit_bit || !typeb_high_speed_bit)
                p1_d = tbcd_pkg::SPD_LOW;
              else
                p1_d = tbcd_pkg::SPD_ALL;
              p3_d = {fwi, tbcd_pkg::NIB_ZERO};
            end
          end
          tbcd_pkg::CMD_ATTR: begin
            if (st_q == tbcd_pkg::TBCD_READY) begin
              st_d = tbcd_pkg::TBCD_ACTIVE;
              attr_d = 1'b1;
            end
          end
          tbcd_pkg::CMD_HLT: begin
            if (st_q == tbcd_pkg::TBCD_READY) begin
              st_d = tbcd_pkg::TBCD_HALT;
              halt_d = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= tbcd_pkg::TBCD_IDLE;
      seen_q <= 1'b0;
      atqb_send <= 1'b0;
      atqb_proto1 <= 8'h00;
      atqb_proto2 <= 8'h00;
      atqb_proto3 <= 8'h00;
      attrib_done <= 1'b0;
      halt_done <= 1'b0;
      select_done <= 1'b0;
      verify_req <= 1'b0;
      mem_rd_req <= 1'b0;
      host_rd_req <= 1'b0;
      mem_wr_req <= 1'b0;
      host_wr_req <= 1'b0;
      card_active <= 1'b0;
    end else begin
      st_q <= st_d;
      seen_q <= seen_d;
      atqb_send <= atqb_d;
      atqb_proto1 <= p1_d;
      atqb_proto2 <= tbcd_pkg::PROTO2_VAL;
      atqb_proto3 <= p3_d;
      attrib_done <= attr_d;
      halt_done <= halt_d;
      select_done <= sel_d;
      verify_req <= ver_d;
      mem_rd_req <= mrd_d;
      host_rd_req <= hrd_d;
      mem_wr_req <= mwr_d;
      host_wr_req <= hwr_d;
      card_active <= st_d == tbcd_pkg::TBCD_ACTIVE;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  logic req_in, idle_s;
  assign req_in = new_cmd && s0_q == tbcd_pkg::CMD_REQ;
  assign idle_s = st_q == tbcd_pkg::TBCD_IDLE;
  property p_afi_any;
    req_in && idle_s && s1_q == tbcd_pkg::AFI_ANY |=> atqb_send;
  endproperty
  a_afi_any: assert property (p_afi_any) else $error("afi 00 ignored");
  property p_afi_hi;
    req_in && s1_q[3:0] == 4'h0 && s1_q[7:4] != 4'h0 &&
      s1_q[7:4] != sys_afi[7:4] |=> !atqb_send;
  endproperty
  a_afi_hi: assert property (p_afi_hi) else $error("upper nibble miss");
  property p_afi_lo;
    req_in && s1_q[7:4] == 4'h0 && s1_q[3:0] != 4'h0 &&
      s1_q[3:0] != sys_afi[3:0] |=> !atqb_send;
  endproperty
  a_afi_lo: assert property (p_afi_lo) else $error("lower nibble miss");
  property p_afi_full;
    req_in && s1_q[7:4] != 4'h0 && s1_q[3:0] != 4'h0 &&
      s1_q != sys_afi |=> !atqb_send;
  endproperty
  a_afi_full: assert property (p_afi_full) else $error("afi mismatch");
  sequence s_attr_cmd;
    new_cmd && st_q == tbcd_pkg::TBCD_READY && s0_q == tbcd_pkg::CMD_ATTR;
  endsequence
  sequence s_activated;
    attrib_done && card_active ##1 card_active [*2];
  endsequence
  property p_attr;
    s_attr_cmd |=> s_activated;
  endproperty
  a_attr: assert property (p_attr) else $error("attrib not taken");
  property p_halt;
    new_cmd && st_q == tbcd_pkg::TBCD_READY && s0_q == tbcd_pkg::CMD_HLT
      |=> halt_done ##1 (!atqb_send && !card_active);
  endproperty
  a_halt: assert property (p_halt) else $error("halt not taken");
  property p_halt_req;
    req_in && st_q == tbcd_pkg::TBCD_HALT && !wake |=> !atqb_send;
  endproperty
  a_halt_req: assert property (p_halt_req) else $error("halt answered");
  property p_rd;
    new_cmd && st_q == tbcd_pkg::TBCD_ACTIVE && s0_q[7:6] == 2'b00 &&
      s2_q == tbcd_pkg::INS_RD
      |=> host_rd_req == $past(tunnel_mode) && mem_rd_req != host_rd_req;
  endproperty
  a_rd: assert property (p_rd) else $error("read misrouted");
  property p_wr;
    new_cmd && st_q == tbcd_pkg::TBCD_ACTIVE && s0_q[7:6] == 2'b00 &&
      s2_q == tbcd_pkg::INS_WR
      |=> host_wr_req == $past(tunnel_mode) && mem_wr_req != host_wr_req;
  endproperty
  a_wr: assert property (p_wr) else $error("write misrouted");
  property p_speed;
    $rose(atqb_send) && $past(radio_speed_limit_bit)
      |-> atqb_proto1 == tbcd_pkg::SPD_LOW;
  endproperty
  a_speed: assert property (p_speed) else $error("speed not limited");
  property p_fwi;
    atqb_send |-> atqb_proto3 == {$past(fwi), 4'h0};
  endproperty
  a_fwi: assert property (p_fwi) else $error("fwi byte wrong");
endmodule

// *** tb/tbcd_reader.sv ***
// reader model that drives framed bytes on a burst link clock
`timescale 1ns/1ps
module tbcd_reader (
  output logic link_clk,
  output logic rx_sof,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_eof,
  input wire logic rx_drop
);
  int drops;
  initial begin
    link_clk = 1'b0;
    rx_sof = 1'b0;
    rx_valid = 1'b0;
    rx_eof = 1'b0;
    rx_byte = 8'h5a;
    drops = 0;
  end
  always @(posedge link_clk) begin
    if (rx_drop === 1'b1) begin
      drops++;
    end
  end
  // the clock only runs in bursts; it stands still between frames
  task automatic tick(input int n);
    repeat (n) begin
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
    end
  endtask
  // byte 0 command or pcb, byte 1 family, byte 2 param or ins
  task automatic frame(input logic [7:0] b0, b1, b2, input int n);
    #7;
    tick(1);
    rx_sof = 1'b1;
    tick(1);
    rx_sof = 1'b0;
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_byte = (i == 0) ? b0 : (i == 1) ? b1 : (i == 2) ? b2 : 8'h00;
      tick(1);
    end
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
    rx_eof = 1'b1;
    tick(1);
    rx_eof = 1'b0;
    // trailing edges let the crossing acknowledge return before next eof
    tick(8);
  endtask
endmodule

// *** tb/tbcd_decoder_bench.sv ***
// self-checking bench for the type b card command decoder
`timescale 1ns/1ps
module tbcd_decoder_bench;
  logic core_clk, rst_b, link_clk, rx_sof, rx_valid, rx_eof, rx_drop;
  logic [7:0] rx_byte, sys_afi, p1, p2, p3;
  logic [3:0] fwi;
  logic lim, hs, tun, act;
  logic [8:0] seen;
  wire [8:0] pl;
  int n_fail, total_checks;
  logic [7:0] afis [8] = '{8'h00, 8'h30, 8'h50, 8'h04, 8'h05, 8'h34,
                           8'h35, 8'h43};
  logic [7:0] amask = 8'h2b;
  logic [7:0] inss [6] = '{8'ha4, 8'h20, 8'hb0, 8'hb0, 8'hd6, 8'hd6};
  logic [8:0] apx [6] = '{9'h020, 9'h010, 9'h008, 9'h004, 9'h002, 9'h001};
  tbcd_reader u_rdr (.link_clk(link_clk), .rx_sof(rx_sof),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_eof(rx_eof),
    .rx_drop(rx_drop));
  tbcd_decoder u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .link_clk(link_clk), .rx_sof(rx_sof), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_eof(rx_eof), .sys_afi(sys_afi), .fwi(fwi),
    .radio_speed_limit_bit(lim), .typeb_high_speed_bit(hs),
    .tunnel_mode(tun), .rx_drop(rx_drop), .atqb_send(pl[8]),
    .atqb_proto1(p1), .atqb_proto2(p2), .atqb_proto3(p3),
    .attrib_done(pl[7]), .halt_done(pl[6]), .select_done(pl[5]),
    .verify_req(pl[4]), .mem_rd_req(pl[3]), .host_rd_req(pl[2]),
    .mem_wr_req(pl[1]), .host_wr_req(pl[0]), .card_active(act));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // pulses last one core cycle, so collect them over the whole command
  always @(posedge core_clk) seen <= seen | pl;
  task automatic check(input string nm, input logic [8:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic reset();
    @(negedge core_clk);
    rst_b = 1'b0;
    u_rdr.tick(3);
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic cmd(input logic [7:0] b0, b1, b2, input int n);
    @(negedge core_clk);
    seen = '0;
    u_rdr.frame(b0, b1, b2, n);
    repeat (4) @(negedge core_clk);
  endtask
  initial begin
    #2ms;
    n_fail++;
    summarize();
  end
  initial begin
    rst_b = 1'b0;
    sys_afi = 8'h34;
    fwi = 4'h0;
    lim = 1'b0;
    hs = 1'b0;
    tun = 1'b0;
    seen = '0;
    n_fail = 0;
    total_checks = 0;
    reset();
    check("active", {8'h00, act}, 9'h000);
    check("proto2", {1'b0, p2}, 9'h081);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      reset();
      lim = i[1];
      hs = i[0];
      fwi = 4'(2 * i + 1);
      cmd(8'h05, afis[i], i[0] ? 8'he7 : 8'h1f, 3);
      check("atqb", seen, {amask[i], 8'h00});
      if (amask[i]) begin
        check("proto1", {1'b0, p1}, (lim || !hs) ? 9'h080 : 9'h0b3);
        check("proto3", {1'b0, p3}, {1'b0, fwi, 4'h0});
      end
    end
    $display("test family filter done");
    reset();
    cmd(8'h05, 8'h00, 8'h00, 3);
    check("req", seen, 9'h100);
    cmd(8'h50, 8'h00, 8'h00, 5);
    check("halt", seen, 9'h040);
    cmd(8'h05, 8'h00, 8'h00, 3);
    check("req_halted", seen, 9'h000);
    cmd(8'h05, 8'h00, 8'h08, 3);
    check("wake_halted", seen, 9'h100);
    cmd(8'h1d, 8'h00, 8'h00, 3);
    check("attrib", seen, 9'h080);
    check("active", {8'h00, act}, 9'h001);
    cmd(8'h05, 8'h00, 8'h00, 3);
    check("req_active", seen, 9'h000);
    for (int i = 0; i < 6; i++) begin
      tun = i[0];
      cmd(8'h02, 8'h00, inss[i], 3);
      check("apdu", seen, apx[i]);
    end
    $display("test states and apdu done");
    reset();
    cmd(8'h05, 8'h00, 8'h00, 257);
    check("long", seen, 9'h000);
    check("drops", 9'(u_rdr.drops), 9'h001);
    cmd(8'h05, 8'h00, 8'h00, 256);
    check("longest", seen, 9'h100);
    check("drops", 9'(u_rdr.drops), 9'h001);
    // an empty data field is refused as well and counts one more drop
    cmd(8'h05, 8'h00, 8'h00, 0);
    check("empty", seen, 9'h000);
    check("drops", 9'(u_rdr.drops), 9'h002);
    $display("test frame length done");
    summarize();
  end
endmodule
